// File: verilog/prl1_pkg.sv
// Purpose: Shared constants and types for the layer 1 defect supervisor
// Assumes: 125 MHz core clock, one frame-synchronous clock domain
// Notes: Timer figures in ms; cycle counts derived here
package prl1_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int unsigned LOSS_MS_MIN = 100;
  localparam int unsigned LOSS_MS_MAX = 1000;
  localparam int unsigned LOSS_MS_DEF = 500;
  localparam int unsigned RECOV_MS_MIN = 10;
  localparam int unsigned RECOV_MS_MAX = 100;
  localparam int unsigned RECOV_MS_DEF = 50;
  localparam int unsigned MS_W = 10;
  localparam int unsigned STAT_W = 8;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_EVENT = 2'h1;
  localparam logic [1:0] ADDR_LOSS_CFG = 2'h2;
  localparam logic [1:0] ADDR_RECOV_CFG = 2'h3;
  localparam int unsigned BIT_PWR = 0;
  localparam int unsigned BIT_LOS = 1;
  localparam int unsigned BIT_LOF = 2;
  localparam int unsigned BIT_CRC = 3;
  localparam int unsigned BIT_RAI = 4;
  localparam int unsigned BIT_AIS = 5;
  localparam int unsigned BIT_ACT = 6;

  typedef struct packed {
    logic power_loss;
    logic signal_loss;
    logic align_loss;
    logic crc_block_error;
    logic block_done;
    logic remote_alarm_flag;
    logic all_ones;
  } prl1_rx_t;

  typedef struct packed {
    logic remote_alarm_flag;
    logic crc_report_valid;
    logic crc_report_bit;
  } prl1_tx_t;

  typedef enum logic [2:0] {
    PRL1_DOWN = 3'h1,
    PRL1_UP = 3'h2,
    PRL1_RECOV = 3'h4
  } prl1_state_t;
endpackage : prl1_pkg

// File: verilog/prl1_ms_tick.sv
// Purpose: 1 ms tick generator from the core clock
// Assumes: Clock enable freezes the count
// Notes: One-cycle pulse every DIV cycles
`timescale 1ns/1ns
module prl1_ms_tick #(
  parameter int unsigned DIV = prl1_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  output logic tick
);
  localparam int unsigned W = $clog2(DIV + 1);
  logic [W-1:0] cnt_reg;
  wire logic wrap = (cnt_reg == W'(DIV - 1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
      tick <= wrap;
    end
  end
endmodule : prl1_ms_tick

// File: verilog/prl1_persist_timer.sv
// Purpose: Millisecond persistence counter with hold and clear
// Assumes: Tick is a one-cycle pulse
// Notes: Expired is a level that holds until clear
`timescale 1ns/1ns
module prl1_persist_timer #(
  parameter int unsigned W = prl1_pkg::MS_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [W-1:0] limit,
  output logic expired,
  output logic [W-1:0] count
);
  wire logic at_limit = (count >= limit);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
      expired <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        count <= '0;
        expired <= 1'b0;
      end else if (run && tick && !at_limit) begin
        count <= count + W'(1);
        expired <= (count + W'(1)) >= limit;
      end
    end
  end
endmodule : prl1_persist_timer

// File: verilog/prl1_supervisor.sv
// Purpose: Layer 1 defect supervisor for a 2048 kbit/s primary rate user side
// Assumes: Framer and CRC checker upstream supply per-frame defect levels
// Notes: Registers over a plain strobe port, read data one cycle later
//
// Summary of operation
// - Detect power loss, incoming signal loss, alignment loss and CRC block errors.
// - Signal loss counts on its own only while alignment is still held.
// - Recognise received remote alarm flag and all-ones alarm signal.
// - Non-normal frames persisting for loss timer issue deactivate indication.
// - Normal frames persisting for recovery timer issue activate indication.
// - Loss timer pauses while recovery timer runs, resumes when it resets.
// - Loss timer clears when recovery timer expires.
// - Any non-normal reception clears the recovery timer.
// - Signal loss sends remote alarm; CRC reports only before alignment loss.
// - Alignment loss sends remote alarm and inhibits CRC reporting.
// - All-ones alarm sends remote alarm, no CRC reports, only after alignment loss.
// - CRC block errors send CRC reports, never remote alarm.
// - CRC reports continue for frames carrying remote alarm flag.
// - Outgoing alarm withdrawn as soon as conditions clear.
// - Remote alarm rides bit 3 of time slot 0 in non-alignment frames.
// - All-ones alarm is a 2048 kbit/s stream of ones.
// - CRC report bit is zero for errored block, one for clean block.
`timescale 1ns/1ns
module prl1_supervisor #(
  parameter int unsigned TICK_DIV = prl1_pkg::TICK_CYCLES,
  parameter int unsigned MS_W = prl1_pkg::MS_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire prl1_pkg::prl1_rx_t rx_in,
  output prl1_pkg::prl1_tx_t tx_out,
  output logic layer1_activate_indication,
  output logic layer1_deactivate_indication,
  output logic layer1_active,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  localparam logic [MS_W-1:0] LOSS_DEF = MS_W'(prl1_pkg::LOSS_MS_DEF);
  localparam logic [MS_W-1:0] RECOV_DEF = MS_W'(prl1_pkg::RECOV_MS_DEF);
  localparam logic [MS_W-1:0] LOSS_LO = MS_W'(prl1_pkg::LOSS_MS_MIN);
  localparam logic [MS_W-1:0] LOSS_HI = MS_W'(prl1_pkg::LOSS_MS_MAX);
  localparam logic [MS_W-1:0] RECOV_LO = MS_W'(prl1_pkg::RECOV_MS_MIN);
  localparam logic [MS_W-1:0] RECOV_HI = MS_W'(prl1_pkg::RECOV_MS_MAX);

  // Detected conditions; signal loss masked once alignment loss already covers it
  wire logic det_pwr = rx_in.power_loss;
  wire logic det_lof = rx_in.align_loss;
  wire logic det_los = rx_in.signal_loss && !rx_in.align_loss;
  wire logic det_crc = rx_in.block_done && rx_in.crc_block_error && !rx_in.align_loss;
  wire logic det_rai = rx_in.remote_alarm_flag && !rx_in.align_loss;
  // All-ones alarm only recognised after alignment loss has been declared
  wire logic det_ais = rx_in.all_ones && rx_in.align_loss;
  wire logic normal_frames = !(det_pwr || rx_in.signal_loss || det_lof || rx_in.all_ones);

  wire logic [prl1_pkg::STAT_W-1:0] status_now;
  logic [prl1_pkg::STAT_W-1:0] status_reg;
  logic [prl1_pkg::STAT_W-1:0] event_reg;
  logic [prl1_pkg::STAT_W-1:0] event_next;
  assign status_now[prl1_pkg::BIT_PWR] = det_pwr;
  assign status_now[prl1_pkg::BIT_LOS] = det_los;
  assign status_now[prl1_pkg::BIT_LOF] = det_lof;
  assign status_now[prl1_pkg::BIT_CRC] = det_crc;
  assign status_now[prl1_pkg::BIT_RAI] = det_rai;
  assign status_now[prl1_pkg::BIT_AIS] = det_ais;
  assign status_now[prl1_pkg::BIT_ACT] = layer1_active;
  assign status_now[prl1_pkg::STAT_W-1] = 1'b0;

  // Register decode
  wire logic wr_event = reg_wr && (reg_addr == prl1_pkg::ADDR_EVENT);
  wire logic wr_loss = reg_wr && (reg_addr == prl1_pkg::ADDR_LOSS_CFG);
  wire logic wr_recov = reg_wr && (reg_addr == prl1_pkg::ADDR_RECOV_CFG);
  wire logic [MS_W-1:0] wdata_ms = reg_wdata[MS_W-1:0];
  logic [MS_W-1:0] loss_cfg_reg;
  logic [MS_W-1:0] recov_cfg_reg;
  logic [MS_W-1:0] loss_lim_reg;
  logic [MS_W-1:0] recov_lim_reg;
  // Out-of-range writes are clamped so the timers always stay legal
  wire logic [MS_W-1:0] loss_wclamp = (wdata_ms < LOSS_LO) ? LOSS_LO :
                                      (wdata_ms > LOSS_HI) ? LOSS_HI : wdata_ms;
  wire logic [MS_W-1:0] recov_wclamp = (wdata_ms < RECOV_LO) ? RECOV_LO :
                                       (wdata_ms > RECOV_HI) ? RECOV_HI : wdata_ms;

  // Events: set on any flag change; write-one-to-clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < prl1_pkg::STAT_W; gi++) begin : g_evt
      assign event_next[gi] = (status_now[gi] != status_reg[gi]) ||
                              (event_reg[gi] && !(wr_event && reg_wdata[gi]));
    end
  endgenerate

  wire logic [15:0] rd_mux =
    (reg_addr == prl1_pkg::ADDR_STATUS) ? 16'(status_reg) :
    (reg_addr == prl1_pkg::ADDR_EVENT) ? 16'(event_reg) :
    (reg_addr == prl1_pkg::ADDR_LOSS_CFG) ? 16'(loss_cfg_reg) : 16'(recov_cfg_reg);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_reg <= '0;
      event_reg <= '0;
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      status_reg <= status_now;
      event_reg <= event_next;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      loss_cfg_reg <= LOSS_DEF;
      recov_cfg_reg <= RECOV_DEF;
    end else if (clk_en) begin
      if (wr_loss) begin
        loss_cfg_reg <= loss_wclamp;
      end
      if (wr_recov) begin
        recov_cfg_reg <= recov_wclamp;
      end
    end
  end

  // Persistence timers and their controls
  wire logic ms_tick;
  wire logic loss_exp;
  wire logic recov_exp;
  wire logic [MS_W-1:0] loss_cnt;
  wire logic [MS_W-1:0] recov_cnt;
  // Loss timer runs only on non-normal reception, so it pauses while recovery runs
  wire logic loss_run = !normal_frames;
  wire logic loss_clear = recov_exp;
  wire logic recov_run = normal_frames;
  wire logic recov_clear = !normal_frames;

  // A new limit is picked up only while its timer is held clear, so a running
  // count never sees its end point move under it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loss_lim_reg <= LOSS_DEF;
      recov_lim_reg <= RECOV_DEF;
    end else if (clk_en) begin
      if (loss_clear) begin
        loss_lim_reg <= loss_cfg_reg;
      end
      if (recov_clear) begin
        recov_lim_reg <= recov_cfg_reg;
      end
    end
  end

  prl1_ms_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(ms_tick)
  );

  prl1_persist_timer #(
    .W(MS_W)
  ) u_loss (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(ms_tick),
    .run(loss_run),
    .clear(loss_clear),
    .limit(loss_lim_reg),
    .expired(loss_exp),
    .count(loss_cnt)
  );

  prl1_persist_timer #(
    .W(MS_W)
  ) u_recov (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(ms_tick),
    .run(recov_run),
    .clear(recov_clear),
    .limit(recov_lim_reg),
    .expired(recov_exp),
    .count(recov_cnt)
  );

  // Outgoing maintenance bits; the framer places the alarm in the spare word
  wire logic send_ra = det_los || det_lof || det_ais;
  // Reports stop while alignment is lost, which also covers the all-ones case
  wire logic crc_report_ok = rx_in.block_done && !rx_in.align_loss;
  prl1_pkg::prl1_tx_t tx_next;
  assign tx_next = '{remote_alarm_flag: send_ra,
                     crc_report_valid: crc_report_ok,
                     crc_report_bit: crc_report_ok && !rx_in.crc_block_error};

  // Down: inactive; up: active and clean; recov: active, faults being timed
  prl1_pkg::prl1_state_t state_reg;
  prl1_pkg::prl1_state_t state_next;
  logic act_next;
  logic deact_next;

  always_comb begin
    state_next = state_reg;
    act_next = 1'b0;
    deact_next = 1'b0;
    unique case (state_reg)
      prl1_pkg::PRL1_DOWN: begin
        if (recov_exp) begin
          state_next = prl1_pkg::PRL1_UP;
          act_next = 1'b1;
        end
      end
      prl1_pkg::PRL1_UP: begin
        if (!normal_frames) begin
          state_next = prl1_pkg::PRL1_RECOV;
        end
      end
      prl1_pkg::PRL1_RECOV: begin
        if (loss_exp) begin
          state_next = prl1_pkg::PRL1_DOWN;
          deact_next = 1'b1;
        end else if (recov_exp) begin
          state_next = prl1_pkg::PRL1_UP;
        end
      end
      default: begin
        state_next = prl1_pkg::PRL1_DOWN;
      end
    endcase
  end

  // Alarm is registered once, so it drops the cycle after its cause clears
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= prl1_pkg::PRL1_DOWN;
      layer1_activate_indication <= 1'b0;
      layer1_deactivate_indication <= 1'b0;
      layer1_active <= 1'b0;
      tx_out <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      layer1_activate_indication <= act_next;
      layer1_deactivate_indication <= deact_next;
      layer1_active <= (state_next != prl1_pkg::PRL1_DOWN);
      tx_out <= tx_next;
    end
  end

  property p_ra_los;
    @(posedge core_clk) disable iff (reset)
    clk_en && det_los |=> tx_out.remote_alarm_flag;
  endproperty
  a_ra_los: assert property (p_ra_los) else $error("alarm missing on signal loss");

  property p_ra_lof;
    @(posedge core_clk) disable iff (reset)
    clk_en && det_lof |=> tx_out.remote_alarm_flag;
  endproperty
  a_ra_lof: assert property (p_ra_lof) else $error("alarm missing on align loss");

  property p_ra_ais;
    @(posedge core_clk) disable iff (reset)
    clk_en && det_ais |=> tx_out.remote_alarm_flag;
  endproperty
  a_ra_ais: assert property (p_ra_ais) else $error("alarm missing on all-ones");

  property p_no_crc_lof;
    @(posedge core_clk) disable iff (reset)
    clk_en && rx_in.align_loss |=> !tx_out.crc_report_valid;
  endproperty
  a_no_crc_lof: assert property (p_no_crc_lof) else $error("report during align loss");

  property p_crc_err;
    @(posedge core_clk) disable iff (reset)
    clk_en && det_crc |=> tx_out.crc_report_valid && !tx_out.crc_report_bit;
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("errored block not reported");

  property p_crc_clean;
    @(posedge core_clk) disable iff (reset)
    clk_en && crc_report_ok && !rx_in.crc_block_error |=>
      tx_out.crc_report_valid && tx_out.crc_report_bit;
  endproperty
  a_crc_clean: assert property (p_crc_clean) else $error("clean block misreported");

  property p_ra_drop;
    @(posedge core_clk) disable iff (reset)
    clk_en && !send_ra |=> !tx_out.remote_alarm_flag;
  endproperty
  a_ra_drop: assert property (p_ra_drop) else $error("alarm held without cause");

  property p_act_cause;
    @(posedge core_clk) disable iff (reset)
    layer1_activate_indication |-> $past(recov_exp) && layer1_active;
  endproperty
  a_act_cause: assert property (p_act_cause) else $error("activate without recovery");

  property p_deact_cause;
    @(posedge core_clk) disable iff (reset)
    layer1_deactivate_indication |-> $past(loss_exp) && !layer1_active;
  endproperty
  a_deact_cause: assert property (p_deact_cause) else $error("deactivate without loss");

  property p_ind_excl;
    @(posedge core_clk) disable iff (reset)
    !(layer1_activate_indication && layer1_deactivate_indication);
  endproperty
  a_ind_excl: assert property (p_ind_excl) else $error("both indications at once");

  property p_loss_hold;
    @(posedge core_clk) disable iff (reset)
    clk_en && normal_frames && !recov_exp |=> $stable(loss_cnt);
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("loss timer not paused");

  property p_loss_clear;
    @(posedge core_clk) disable iff (reset)
    clk_en && recov_exp |=> (loss_cnt == '0) && !loss_exp;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("loss timer not cleared");

  property p_recov_clear;
    @(posedge core_clk) disable iff (reset)
    clk_en && !normal_frames |=> (recov_cnt == '0) && !recov_exp;
  endproperty
  a_recov_clear: assert property (p_recov_clear) else $error("recovery timer not cleared");
endmodule : prl1_supervisor

// File: tb/prl1_line_model.sv
// Purpose: Far-side line equipment feeding the supervisor receive side
// Assumes: Mode picks the line condition, one CRC block every 8 cycles
// Notes: Behavioural; 0 normal, 1 align loss, 2 signal loss, 3 all-ones, 4 CRC+flag, 5 power
`timescale 1ns/1ns
module prl1_line_model (
  input wire logic core_clk,
  input wire logic [2:0] mode,
  output prl1_pkg::prl1_rx_t rx
);
  logic [2:0] phase_reg = 3'h0;
  wire frame_ok = (mode == 3'h0) || (mode == 3'h4);
  always_ff @(posedge core_clk) begin
    phase_reg <= phase_reg + 3'h1;
  end
  always_comb begin
    rx = '0;
    rx.power_loss = (mode == 3'h5);
    rx.signal_loss = (mode == 3'h2);
    rx.align_loss = !frame_ok;
    // Upstream link equipment replaces a lost signal by all ones
    rx.all_ones = (mode == 3'h3) || (mode == 3'h2);
    rx.block_done = frame_ok && (phase_reg == 3'h7);
    rx.crc_block_error = (mode == 3'h4) && rx.block_done;
    rx.remote_alarm_flag = (mode == 3'h4);
  end
endmodule : prl1_line_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the layer 1 defect supervisor
// Assumes: Short tick divider keeps the millisecond timers quick
// Notes: Waits are bounded; expectations come from package constants
`timescale 1ns/1ns
module tb_top;
  localparam int DIV = 4;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] mode = 3'h0;
  prl1_pkg::prl1_rx_t rx_in;
  prl1_pkg::prl1_tx_t tx_out;
  logic act_ind, deact_ind, l1_active;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, rd_val;
  int fails = 0;
  int num_checks = 0;
  int n;
  wire [4:0] watch = {tx_out.crc_report_valid, ~tx_out.remote_alarm_flag,
                      tx_out.remote_alarm_flag, deact_ind, act_ind};
  always #4 core_clk = ~core_clk;
  prl1_line_model line (.core_clk(core_clk), .mode(mode), .rx(rx_in));
  prl1_supervisor #(.TICK_DIV(DIV)) uut (.core_clk(core_clk), .reset(reset),
    .clk_en(1'b1), .rx_in(rx_in), .tx_out(tx_out),
    .layer1_activate_indication(act_ind), .layer1_deactivate_indication(deact_ind),
    .layer1_active(l1_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : reg_read
  task automatic wait_hi(input int sel, input int bound);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (watch[sel] !== 1'b1 && n < bound);
    if (watch[sel] !== 1'b1) begin
      $display("[FAIL] wait %0d expected 1 seen timeout", sel);
      fails++;
      close_out();
    end
  endtask : wait_hi
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    reg_read(prl1_pkg::ADDR_LOSS_CFG);
    check("loss_cfg", rd_val, 16'(prl1_pkg::LOSS_MS_DEF));
    reg_read(prl1_pkg::ADDR_RECOV_CFG);
    check("recov_cfg", rd_val, 16'(prl1_pkg::RECOV_MS_DEF));
    reg_write(prl1_pkg::ADDR_LOSS_CFG, 16'h0064);
    reg_read(prl1_pkg::ADDR_LOSS_CFG);
    check("loss_cfg_wr", rd_val, 16'h0064);
    wait_hi(0, 4000);
    check("act_delay", 16'(n >= prl1_pkg::RECOV_MS_MIN * DIV), 16'h1);
    #8 check("active", 16'(l1_active), 16'h1);
    mode <= 3'h1;
    wait_hi(2, 20);
    repeat (16) begin
      @(posedge core_clk);
      #1 check("no_crc_lof", 16'(tx_out.crc_report_valid), 16'h0);
    end
    wait_hi(1, 8000);
    check("deact_delay", 16'(n >= prl1_pkg::LOSS_MS_MIN * DIV - 80), 16'h1);
    reg_read(prl1_pkg::ADDR_STATUS);
    check("stat_lof", 16'(rd_val[prl1_pkg::BIT_LOF]), 16'h1);
    reg_read(prl1_pkg::ADDR_EVENT);
    check("evt_lof", 16'(rd_val[prl1_pkg::BIT_LOF]), 16'h1);
    mode <= 3'h3;
    repeat (8) @(posedge core_clk);
    check("ra_ais", 16'(tx_out.remote_alarm_flag), 16'h1);
    reg_read(prl1_pkg::ADDR_STATUS);
    check("stat_ais", 16'(rd_val[prl1_pkg::BIT_AIS]), 16'h1);
    mode <= 3'h0;
    wait_hi(3, 20);
    repeat (100) @(posedge core_clk);
    mode <= 3'h1;
    repeat (10) @(posedge core_clk);
    mode <= 3'h0;
    wait_hi(0, 4000);
    check("recov_restart", 16'(n >= prl1_pkg::RECOV_MS_DEF * DIV - DIV), 16'h1);
    mode <= 3'h4;
    wait_hi(4, 40);
    check("crc_bit_err", 16'(tx_out.crc_report_bit), 16'h0);
    check("no_ra_crc", 16'(tx_out.remote_alarm_flag), 16'h0);
    mode <= 3'h0;
    repeat (2) @(posedge core_clk);
    wait_hi(4, 40);
    check("crc_bit_ok", 16'(tx_out.crc_report_bit), 16'h1);
    mode <= 3'h2;
    wait_hi(2, 20);
    mode <= 3'h5;
    repeat (4) @(posedge core_clk);
    reg_read(prl1_pkg::ADDR_STATUS);
    check("stat_pwr", 16'(rd_val[prl1_pkg::BIT_PWR]), 16'h1);
    close_out();
  end
endmodule : tb_top
